// file: setup_params.svh
/*
 * Constants for the setup and expansion parameter block: command codes,
 * reset values, bounds and key-hold timing.
 * Assumes inclusion once per compile unit by bare name.
 */
`ifndef SETUP_PARAMS_SVH
`define SETUP_PARAMS_SVH

`define CLK_FREQ_HZ 20000000
`define HOLD_TIME_MS 1000
`define HOLD_CYCLES ((`CLK_FREQ_HZ / 1000) * `HOLD_TIME_MS)

`define ALM_TYPE_MIN 4'h1
`define ALM_TYPE_MAX 4'hB
`define ALM_TYPE_DEF 4'h2

`define SP_HIGH_DEF 16'sh0514
`define SP_LOW_DEF 16'shFF38
`define SCALE_HIGH_DEF 16'sh0064
`define SCALE_LOW_DEF 16'sh0000
`define SECURITY_DEF 3'h1

`define CMD_ALM_TYPE 4'h0
`define CMD_ALM_POL 4'h1
`define CMD_ACTION 4'h2
`define CMD_SP_HIGH 4'h3
`define CMD_SP_LOW 4'h4
`define CMD_SET_POINT 4'h5
`define CMD_METHOD 4'h6
`define CMD_PWR_ON 4'h7
`define CMD_INIT 4'h8
`define REG_STATUS 4'hE
`define REG_MASK 4'hF

`endif

// file: setup_pkg.sv
/*
 * Types for the setup and expansion parameter block.
 * Assumes setup_params.svh supplies the numeric constants.
 */
package setup_pkg;

    typedef enum logic [1:0] {
        PWR_CONTINUE = 2'b00,
        PWR_RESET = 2'b01,
        PWR_RUN = 2'b10,
        PWR_MANUAL = 2'b11
    } pwr_on_e;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_MENU = 2'b01,
        KEY_WAIT = 2'b10
    } key_state_e;

    typedef struct packed {
        logic [3:0] cmd;
        logic [1:0] chan;
        logic [15:0] data;
    } param_wr_s;

    typedef struct packed {
        logic signed [15:0] high;
        logic signed [15:0] low;
    } range_s;

endpackage : setup_pkg

// file: setup_params.sv
/*
 * Setup and expansion parameter logic of a process controller: alarm type
 * and polarity, control action, set point limiter, control method, power-on
 * action and protected menu entry.
 * Assumes synchronous key and write inputs on CLK, and an external sensor
 * range table feeding SENSOR_HIGH/SENSOR_LOW.
 */
`timescale 1ns/1ps
`include "setup_params.svh"

// Functional notes
// [R1] three alarms, type codes one to eleven
// [R2] initialisation sets every alarm type to two
// [R3] close-in-alarm output follows alarm state
// [R4] open-in-alarm output is inverted alarm state
// [R5] led follows alarm state, any polarity
// [R6] direct raises output with value; reverse opposite
// [R7] expansion menu usable only at security 0/1
// [R8] menu and mode each need one-second hold
// [R9] new set point accepted only within bounds
// [R10] bound rewrite clamps stored set point
// [R11] sensor or unit change loads sensor limits
// [R12] high bound: low+1 to limit, default 1300
// [R13] low bound: limit to high-1, default -200
// [R14] temperature input uses sensor range limits
// [R15] decimal position from sensor or scaling
// [R16] method select pid or on/off, default pid
// [R17] power-up action selectable, default continue
// [R18] manual power-up refused when key protected
// [R19] invalid alarm type writes leave code unchanged
module setup_params
    import setup_pkg::*;
(
    input wire logic CLK, // system clock
    input wire logic RESETN, // async reset, active low
    input wire logic [3:0] ADDR, // register address
    input wire logic [15:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [15:0] RDATA, // read data, one cycle later
    input wire logic MODE_KEY, // mode key held
    input wire logic [2:0] SECURITY, // protect security setting
    input wire logic AM_KEY_PROTECT, // auto/manual key protected
    input wire logic TEMP_INPUT, // temperature input selected
    input wire logic SENSOR_CHANGE, // input type or unit changed, pulse
    input wire logic signed [15:0] SENSOR_HIGH, // sensor range upper limit
    input wire logic signed [15:0] SENSOR_LOW, // sensor range lower limit
    input wire logic [1:0] SENSOR_DP, // sensor decimal position
    input wire logic signed [15:0] SCALE_HIGH, // scaling upper limit
    input wire logic signed [15:0] SCALE_LOW, // scaling lower limit
    input wire logic [1:0] SCALE_DP, // scaling decimal position
    input wire logic STD_OR_HEATCOOL, // standard or heat/cool control
    input wire logic [2:0] ALARM_FUNC, // internal alarm states
    input wire logic signed [15:0] PV_ERROR, // process value minus set point
    input wire logic POWER_UP, // power-up event, pulse
    output logic [2:0] ALARM_OUT, // physical alarm outputs
    output logic [2:0] ALARM_LED, // alarm indicator leds
    output logic signed [15:0] MV_DRIVE, // action-signed error for pid
    output logic signed [15:0] SET_POINT, // stored set point
    output logic [1:0] SP_DECIMAL, // set point decimal position
    output logic ONOFF_ACTIVE, // on/off control in force
    output logic MENU_OPEN, // menu display shown
    output logic EXP_MODE, // expansion mode entered
    output logic [1:0] PWR_ACTION, // action taken at power-up
    output logic PWR_ACTION_VALID, // power-up action pulse
    output logic IRQ // level interrupt
);

    localparam int HOLD_N = `HOLD_CYCLES;

    function automatic logic signed [15:0] clamp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        if (v > hi) begin
            return hi;
        end
        if (v < lo) begin
            return lo;
        end
        return v;
    endfunction : clamp

    function automatic logic in_range(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        return (v >= lo) && (v <= hi);
    endfunction : in_range

    // registers software may still reach while the menu is locked
    function automatic logic lock_exempt(input logic [3:0] a);
        return (a == `CMD_SET_POINT) || (a == `REG_STATUS) || (a == `REG_MASK);
    endfunction : lock_exempt

    logic [3:0] alm_type_ff [3];
    logic [2:0] alm_open_ff;
    logic reverse_ff;
    range_s bound_ff;
    logic signed [15:0] sp_ff;
    logic onoff_ff;
    pwr_on_e pwr_sel_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [15:0] rdata_ff;
    key_state_e key_ff;
    logic [24:0] hold_cnt_ff;
    logic [1:0] pwr_act_ff;
    logic pwr_vld_ff;
    logic exp_ff;

    param_wr_s wr_req;
    assign wr_req = '{cmd: ADDR, chan: WDATA[13:12], data: WDATA};

    // [R7] expansion parameters locked above security 1
    wire exp_unlocked = (SECURITY <= 3'h1);
    wire wr_any = WR && exp_unlocked;
    // [R14] temperature input limits by sensor range
    range_s lim;
    assign lim.high = TEMP_INPUT ? SENSOR_HIGH : SCALE_HIGH;
    assign lim.low = TEMP_INPUT ? SENSOR_LOW : SCALE_LOW;
    wire signed [15:0] wval = signed'(wr_req.data);
    wire [3:0] wtype = wr_req.data[3:0];
    // [R1] [R19] type code checked before store
    wire type_ok = (wtype >= `ALM_TYPE_MIN) && (wtype <= `ALM_TYPE_MAX)
        && (wr_req.chan != 2'h3);
    wire wr_type = wr_any && (wr_req.cmd == `CMD_ALM_TYPE) && type_ok;
    // [R12] high bound range check
    wire hi_ok = in_range(wval, bound_ff.low + 16'sh0001, lim.high);
    // [R13] low bound range check
    wire lo_ok = in_range(wval, lim.low, bound_ff.high - 16'sh0001);
    wire wr_hi = wr_any && (wr_req.cmd == `CMD_SP_HIGH) && hi_ok;
    wire wr_lo = wr_any && (wr_req.cmd == `CMD_SP_LOW) && lo_ok;
    // [R9] set point within bounds only
    wire sp_ok = in_range(wval, bound_ff.low, bound_ff.high);
    wire wr_sp = WR && (wr_req.cmd == `CMD_SET_POINT) && sp_ok;
    // [R18] manual refused when key protected
    wire pwr_ok = !(pwr_on_e'(wr_req.data[1:0]) == PWR_MANUAL && AM_KEY_PROTECT);
    wire wr_pwr = wr_any && (wr_req.cmd == `CMD_PWR_ON) && pwr_ok;
    wire wr_init = wr_any && (wr_req.cmd == `CMD_INIT);
    // polarity, action and method writes share the lock
    wire wr_pol = wr_any && (wr_req.cmd == `CMD_ALM_POL);
    wire wr_act = wr_any && (wr_req.cmd == `CMD_ACTION);
    wire wr_meth = wr_any && (wr_req.cmd == `CMD_METHOD);
    // locked write to a parameter that the lock covers
    wire wr_reject = WR && !exp_unlocked && !lock_exempt(ADDR);

    range_s nxt_bound;
    always_comb begin
        nxt_bound = bound_ff;
        // [R11] sensor change forces sensor limits
        if (SENSOR_CHANGE && TEMP_INPUT) begin
            nxt_bound.high = SENSOR_HIGH;
            nxt_bound.low = SENSOR_LOW;
        end else if (wr_init) begin
            nxt_bound.high = `SP_HIGH_DEF;
            nxt_bound.low = `SP_LOW_DEF;
        end else if (wr_hi) begin
            nxt_bound.high = wval;
        end else if (wr_lo) begin
            nxt_bound.low = wval;
        end
    end

    // [R10] stored set point clamped to bounds
    wire signed [15:0] nxt_sp = wr_sp ? wval : clamp(sp_ff, nxt_bound.low, nxt_bound.high);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bound_ff <= '{high: `SP_HIGH_DEF, low: `SP_LOW_DEF};
        end else begin
            bound_ff <= nxt_bound;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sp_ff <= 16'sh0000;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // [R2] initialisation restores type two
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 3; i++) begin
                alm_type_ff[i] <= `ALM_TYPE_DEF;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_init) begin
                    alm_type_ff[i] <= `ALM_TYPE_DEF;
                end else if (wr_type && wr_req.chan == 2'(i)) begin
                    alm_type_ff[i] <= wtype;
                end
            end
        end
    end

    // polarity bits, one per channel, set means open in alarm
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            alm_open_ff <= 3'h0;
        end else if (wr_init) begin
            alm_open_ff <= 3'h0;
        end else if (wr_pol) begin
            alm_open_ff <= wr_req.data[2:0];
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            reverse_ff <= 1'b1;
        end else if (wr_init) begin
            reverse_ff <= 1'b1;
        end else if (wr_act) begin
            reverse_ff <= wr_req.data[0];
        end
    end

    // [R16] method defaults to pid
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            onoff_ff <= 1'b0;
        end else if (wr_init) begin
            onoff_ff <= 1'b0;
        end else if (wr_meth) begin
            onoff_ff <= wr_req.data[0];
        end
    end

    // [R17] resume is the default
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pwr_sel_ff <= PWR_CONTINUE;
        end else if (wr_init) begin
            pwr_sel_ff <= PWR_CONTINUE;
        end else if (wr_pwr) begin
            pwr_sel_ff <= pwr_on_e'(wr_req.data[1:0]);
        end
    end

    // [R3] [R4] polarity applied per channel
    assign ALARM_OUT = ALARM_FUNC ^ alm_open_ff;
    // [R5] led ignores polarity
    assign ALARM_LED = ALARM_FUNC;
    // [R6] reverse action negates error sign
    assign MV_DRIVE = reverse_ff ? -PV_ERROR : PV_ERROR;
    assign SET_POINT = sp_ff;
    // [R15] decimal position source
    assign SP_DECIMAL = TEMP_INPUT ? SENSOR_DP : SCALE_DP;
    // [R16] on/off only for standard or heat/cool
    assign ONOFF_ACTIVE = onoff_ff && STD_OR_HEATCOOL;

    // [R8] hold mode key one second twice
    wire hold_done = (hold_cnt_ff == 25'(HOLD_N - 1));
    // count restarts on release, after each full hold and while key_ff is KEY_MENU
    wire hold_clr = !MODE_KEY || hold_done || (key_ff == KEY_MENU);
    wire [24:0] nxt_hold = hold_clr ? 25'h0000000 : hold_cnt_ff + 25'h0000001;
    key_state_e nxt_key;
    always_comb begin
        nxt_key = key_ff;
        unique case (key_ff)
            KEY_IDLE: begin
                if (MODE_KEY && hold_done) begin
                    nxt_key = KEY_MENU;
                end
            end
            KEY_MENU: begin
                if (!MODE_KEY) begin
                    nxt_key = KEY_WAIT;
                end
            end
            KEY_WAIT: begin
                if (MODE_KEY && hold_done) begin
                    nxt_key = KEY_IDLE;
                end
            end
            default: begin
                nxt_key = KEY_IDLE;
            end
        endcase
    end
    wire menu_enter = (key_ff == KEY_IDLE) && (nxt_key == KEY_MENU);
    wire mode_enter = (key_ff == KEY_WAIT) && (nxt_key == KEY_IDLE);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            key_ff <= KEY_IDLE;
            hold_cnt_ff <= 25'h0000000;
        end else begin
            key_ff <= nxt_key;
            hold_cnt_ff <= nxt_hold;
        end
    end

    // [R7] mode entry only when unlocked
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            exp_ff <= 1'b0;
        end else if (mode_enter) begin
            exp_ff <= exp_unlocked;
        end else if (menu_enter) begin
            exp_ff <= 1'b0;
        end
    end
    assign MENU_OPEN = (key_ff != KEY_IDLE);
    assign EXP_MODE = exp_ff;

    // [R17] power-up action issued
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pwr_act_ff <= 2'h0;
            pwr_vld_ff <= 1'b0;
        end else begin
            pwr_vld_ff <= POWER_UP;
            if (POWER_UP) begin
                pwr_act_ff <= pwr_sel_ff;
            end
        end
    end
    assign PWR_ACTION = pwr_act_ff;
    assign PWR_ACTION_VALID = pwr_vld_ff;

    // events: rejected write, bound clamp, sensor reload, power-up
    wire ev_clamp = (nxt_sp != sp_ff) && !wr_sp;
    wire ev_reload = SENSOR_CHANGE && TEMP_INPUT;
    wire [3:0] events = {POWER_UP, ev_reload, ev_clamp, wr_reject};
    wire wr_status = WR && (ADDR == `REG_STATUS);
    wire wr_mask = WR && (ADDR == `REG_MASK);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            status_ff <= 4'h0;
            mask_ff <= 4'h0;
        end else begin
            status_ff <= (status_ff & ~(wr_status ? WDATA[3:0] : 4'h0)) | events;
            if (wr_mask) begin
                mask_ff <= WDATA[3:0];
            end
        end
    end
    assign IRQ = |(status_ff & mask_ff);

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (ADDR)
            `CMD_ALM_TYPE: rd_mux = {4'h0, alm_type_ff[2], alm_type_ff[1], alm_type_ff[0]};
            `CMD_ALM_POL: rd_mux = {13'h0000, alm_open_ff};
            `CMD_ACTION: rd_mux = {15'h0000, reverse_ff};
            `CMD_SP_HIGH: rd_mux = bound_ff.high;
            `CMD_SP_LOW: rd_mux = bound_ff.low;
            `CMD_SET_POINT: rd_mux = sp_ff;
            `CMD_METHOD: rd_mux = {15'h0000, onoff_ff};
            `CMD_PWR_ON: rd_mux = {14'h0000, pwr_sel_ff};
            `REG_STATUS: rd_mux = {12'h000, status_ff};
            `REG_MASK: rd_mux = {12'h000, mask_ff};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= RD ? rd_mux : 16'h0000;
        end
    end
    assign RDATA = rdata_ff;

endmodule : setup_params

// file: panel_model.sv
/*
 * Front-panel model: mode key and the alarm function states.
 * Assumes the bench sets the requests just after a rising edge.
 */
`timescale 1ns/1ps
module panel_model (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [2:0] func_req, // wanted alarm states
    input wire logic key_req, // press the mode key
    output logic [2:0] alarm_func_ff, // alarm states to the block
    output logic mode_key_ff // mode key level
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_func_ff <= 3'h0;
            mode_key_ff <= 1'b0;
        end else begin
            alarm_func_ff <= func_req;
            mode_key_ff <= key_req;
        end
    end
endmodule : panel_model

// file: setup_params_sva.sv
/*
 * Port checker for the setup parameter block.
 * Assumes one clock domain and the hold count of the shared header.
 */
`timescale 1ns/1ps
`include "setup_params.svh"
module setup_params_sva (
    input wire logic CLK, // clock
    input wire logic RESETN, // reset, active low
    input wire logic [3:0] ADDR, // address
    input wire logic WR, // write strobe
    input wire logic MODE_KEY, // key level
    input wire logic [2:0] SECURITY, // security
    input wire logic STD_OR_HEATCOOL, // control kind
    input wire logic SENSOR_CHANGE, // sensor change
    input wire logic POWER_UP, // power-up pulse
    input wire logic [2:0] ALARM_FUNC, // alarm states
    input wire logic signed [15:0] PV_ERROR, // error in
    input wire logic [2:0] ALARM_OUT, // alarm outputs
    input wire logic [2:0] ALARM_LED, // leds
    input wire logic signed [15:0] MV_DRIVE, // drive
    input wire logic signed [15:0] SET_POINT, // set point
    input wire logic ONOFF_ACTIVE, // on/off
    input wire logic MENU_OPEN, // menu
    input wire logic EXP_MODE, // expansion mode
    input wire logic PWR_ACTION_VALID // power-up pulse out
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic [24:0] held_ff;
    logic [24:0] nxt_held;
    assign nxt_held = MODE_KEY ? held_ff + 25'h1 : 25'h0;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) held_ff <= 25'h0;
        else held_ff <= nxt_held;
    end
    sequence quiet_s;
        !SENSOR_CHANGE && !(WR && ADDR inside {4'h3, 4'h4, 4'h5, 4'h8});
    endsequence
    sequence one_pulse_s;
        PWR_ACTION_VALID ##1 !PWR_ACTION_VALID;
    endsequence
    led_follow_a: assert property (ALARM_LED == ALARM_FUNC)
        else $error("led differs from alarm state");
    pol_steady_a: assert property (!(WR && ADDR inside {4'h1, 4'h8})
        |=> $stable(ALARM_OUT ^ ALARM_FUNC)) else $error("polarity moved");
    mv_sign_a: assert property (MV_DRIVE == PV_ERROR || MV_DRIVE == -PV_ERROR)
        else $error("drive not signed error");
    onoff_std_a: assert property (ONOFF_ACTIVE |-> STD_OR_HEATCOOL)
        else $error("on/off outside standard control");
    sp_hold_a: assert property (quiet_s ##1 quiet_s |=> $stable(SET_POINT))
        else $error("set point changed uncommanded");
    pwr_pulse_a: assert property (POWER_UP |=> one_pulse_s)
        else $error("power-up pulse wrong");
    menu_hold_a: assert property ($rose(MENU_OPEN) |-> held_ff >= 25'(`HOLD_CYCLES - 1))
        else $error("menu opened early");
    exp_sec_a: assert property ($rose(EXP_MODE) |-> $past(SECURITY) <= 3'h1)
        else $error("expansion entered while locked");
endmodule : setup_params_sva
bind setup_params setup_params_sva u_sva (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WR(WR),
    .MODE_KEY(MODE_KEY), .SECURITY(SECURITY), .STD_OR_HEATCOOL(STD_OR_HEATCOOL),
    .SENSOR_CHANGE(SENSOR_CHANGE), .POWER_UP(POWER_UP), .ALARM_FUNC(ALARM_FUNC),
    .PV_ERROR(PV_ERROR), .ALARM_OUT(ALARM_OUT), .ALARM_LED(ALARM_LED), .MV_DRIVE(MV_DRIVE),
    .SET_POINT(SET_POINT), .ONOFF_ACTIVE(ONOFF_ACTIVE), .MENU_OPEN(MENU_OPEN),
    .EXP_MODE(EXP_MODE), .PWR_ACTION_VALID(PWR_ACTION_VALID));

// file: setup_params_tb_top.sv
/*
 * Self-checking bench for the setup parameter block.
 * Assumes the panel model and the bound checker compile beside it.
 */
`timescale 1ns/1ps
module setup_params_tb_top;
    import setup_pkg::*;
    logic CLK = 0, RESETN = 0, WR = 0, RD = 0, AM_KEY_PROTECT = 0, TEMP_INPUT = 0;
    logic SENSOR_CHANGE = 0, STD_OR_HEATCOOL = 1, POWER_UP = 0, key_req = 0, MODE_KEY;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0, RDATA;
    logic [2:0] SECURITY = 3'h0, func_req = 3'h0, ALARM_FUNC, ALARM_OUT, ALARM_LED;
    logic signed [15:0] PV_ERROR = 16'sh0005, MV_DRIVE, SET_POINT;
    logic [1:0] SP_DECIMAL, PWR_ACTION;
    logic [1:0] SCALE_DP = 2'h1;
    logic ONOFF_ACTIVE, MENU_OPEN, EXP_MODE, PWR_ACTION_VALID, IRQ;
    int miscompares = 0, compares = 0;
    panel_model i_panel (.clk(CLK), .resetn(RESETN), .func_req(func_req), .key_req(key_req),
        .alarm_func_ff(ALARM_FUNC), .mode_key_ff(MODE_KEY));
    setup_params i_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .MODE_KEY(MODE_KEY), .SECURITY(SECURITY),
        .AM_KEY_PROTECT(AM_KEY_PROTECT), .TEMP_INPUT(TEMP_INPUT), .SENSOR_CHANGE(SENSOR_CHANGE),
        .SENSOR_HIGH(16'sh0190), .SENSOR_LOW(16'shFF9C), .SENSOR_DP(2'h2),
        .SCALE_HIGH(16'sh07D0), .SCALE_LOW(16'shFC18), .SCALE_DP(SCALE_DP),
        .STD_OR_HEATCOOL(STD_OR_HEATCOOL), .ALARM_FUNC(ALARM_FUNC), .PV_ERROR(PV_ERROR),
        .POWER_UP(POWER_UP), .ALARM_OUT(ALARM_OUT), .ALARM_LED(ALARM_LED), .MV_DRIVE(MV_DRIVE),
        .SET_POINT(SET_POINT), .SP_DECIMAL(SP_DECIMAL), .ONOFF_ACTIVE(ONOFF_ACTIVE),
        .MENU_OPEN(MENU_OPEN), .EXP_MODE(EXP_MODE), .PWR_ACTION(PWR_ACTION),
        .PWR_ACTION_VALID(PWR_ACTION_VALID), .IRQ(IRQ));
    initial begin
        forever #25 CLK = ~CLK;
    end
    task check(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask : wr
    task rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 check("rdata", RDATA, e);
    endtask : rd_chk
    task t_defaults;
        rd_chk(4'h0, 16'h0222);
        rd_chk(4'h3, 16'h0514);
        rd_chk(4'h4, 16'hFF38);
        rd_chk(4'h6, 16'h0000);
        rd_chk(4'h7, 16'h0000);
        rd_chk(4'h9, 16'h0000);
    endtask : t_defaults
    task t_alarm_type;
        wr(4'h0, 16'h200B);
        rd_chk(4'h0, 16'h0B22);
        wr(4'h0, 16'h2000);
        wr(4'h0, 16'h200C);
        wr(4'h0, 16'h3001);
        rd_chk(4'h0, 16'h0B22);
        wr(4'h8, 16'h0001);
        rd_chk(4'h0, 16'h0222);
    endtask : t_alarm_type
    task t_polarity;
        wr(4'h1, 16'h0005);
        for (int f = 0; f < 8; f++) begin
            @(posedge CLK) func_req <= 3'(f);
            repeat (2) @(posedge CLK);
            #1 check("alarm_out", {13'h0, ALARM_OUT}, {13'h0, 3'(f) ^ 3'h5});
            check("alarm_led", {13'h0, ALARM_LED}, {13'h0, 3'(f)});
        end
    endtask : t_polarity
    task t_action;
        wr(4'h2, 16'h0000);
        check("mv_direct", MV_DRIVE, 16'h0005);
        wr(4'h2, 16'h0001);
        check("mv_reverse", MV_DRIVE, 16'hFFFB);
    endtask : t_action
    task t_set_point;
        wr(4'h5, 16'h0064);
        check("sp_ok", SET_POINT, 16'h0064);
        wr(4'h5, 16'h07D0);
        check("sp_over", SET_POINT, 16'h0064);
        wr(4'h5, 16'h0514);
        wr(4'h3, 16'h01F4);
        rd_chk(4'h3, 16'h01F4);
        check("sp_clamp", SET_POINT, 16'h01F4);
        wr(4'h4, 16'h0258);
        rd_chk(4'h4, 16'hFF38);
        wr(4'h4, 16'h01F3);
        wr(4'h3, 16'h01F3);
        rd_chk(4'h3, 16'h01F4);
    endtask : t_set_point
    task t_sensor;
        @(posedge CLK) TEMP_INPUT <= 1'b1;
        SENSOR_CHANGE <= 1'b1;
        @(posedge CLK) SENSOR_CHANGE <= 1'b0;
        rd_chk(4'h3, 16'h0190);
        rd_chk(4'h4, 16'hFF9C);
        check("sp_sensor", SET_POINT, 16'h0190);
        check("dp_temp", {14'h0, SP_DECIMAL}, 16'h0002);
        @(posedge CLK) TEMP_INPUT <= 1'b0;
        @(posedge CLK) #1 check("dp_scale", {14'h0, SP_DECIMAL}, 16'h0001);
        @(posedge CLK) SCALE_DP <= 2'h3;
        @(posedge CLK) #1 check("dp_scale3", {14'h0, SP_DECIMAL}, 16'h0003);
    endtask : t_sensor
    task t_security;
        @(posedge CLK) SECURITY <= 3'h2;
        wr(4'h6, 16'h0001);
        rd_chk(4'h6, 16'h0000);
        check("irq_masked", {15'h0, IRQ}, 16'h0000);
        wr(4'hF, 16'h0001);
        check("irq_on", {15'h0, IRQ}, 16'h0001);
        wr(4'hE, 16'h0001);
        check("irq_clear", {15'h0, IRQ}, 16'h0000);
        @(posedge CLK) SECURITY <= 3'h0;
        wr(4'h6, 16'h0001);
        check("onoff", {15'h0, ONOFF_ACTIVE}, 16'h0001);
        @(posedge CLK) STD_OR_HEATCOOL <= 1'b0;
        @(posedge CLK) #1 check("onoff_off", {15'h0, ONOFF_ACTIVE}, 16'h0000);
    endtask : t_security
    task t_power;
        @(posedge CLK) AM_KEY_PROTECT <= 1'b1;
        wr(4'h7, 16'h0003);
        rd_chk(4'h7, 16'h0000);
        for (int m = 2; m >= 0; m--) begin
            wr(4'h7, 16'(m));
            @(posedge CLK) POWER_UP <= 1'b1;
            @(posedge CLK) POWER_UP <= 1'b0;
            #1 check("pwr_valid", {15'h0, PWR_ACTION_VALID}, 16'h0001);
            check("pwr_action", {14'h0, PWR_ACTION}, 16'(m));
        end
        @(posedge CLK) AM_KEY_PROTECT <= 1'b0;
        wr(4'h7, 16'h0003);
        rd_chk(4'h7, 16'h0003);
    endtask : t_power
    task t_key;
        @(posedge CLK) key_req <= 1'b1;
        repeat (20) @(posedge CLK);
        #1 check("menu_short", {15'h0, MENU_OPEN}, 16'h0000);
        @(posedge CLK) key_req <= 1'b0;
        repeat (2) @(posedge CLK);
        #1 check("exp_short", {15'h0, EXP_MODE}, 16'h0000);
    endtask : t_key
    task close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    initial begin
        repeat (5000) @(posedge CLK);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        t_defaults;
        t_alarm_type;
        t_polarity;
        t_action;
        t_set_point;
        t_sensor;
        t_security;
        t_power;
        t_key;
        close_out;
    end
endmodule : setup_params_tb_top
